/* rtl/pam_top.sv */
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
// Function
// - Every general purpose port line has one alternate function besides latch and direction.
// - Alternate output reaches pin only with direction bit set.
// - Pin output is latch AND alternate data, except bypassed PWM lines.
// - All direction bits are zero after reset.
// - Alternate input sees the latch when the pin is output.
// - Multiplexed bus port switches direction automatically during accesses.
// - Segment port drives upper address bits when segmentation enabled.
// - Strobe line takes its role from start-up straps after reset.
// - Strobe role enables the line driver automatically.
// - During hold the strobe line is plain latch and direction controlled.
// - Unused alternate lines work as general purpose input/output.
// - Byte-high disable zero enables strobe, one frees the line while write configuration is zero.
// - Write configuration one makes write low and write high strobes.
module pam_top
#(
	parameter int unsigned GP_W  = 16,
	parameter int unsigned BUS_W = 16,
	parameter int unsigned SEG_W = 8
)
(
	input  wire logic                      CORE_CLK_I,
	input  wire logic                      RSTN_I,
	input  wire logic                      PSEL_I,
	input  wire logic                      PENABLE_I,
	input  wire logic                      PWRITE_I,
	input  wire logic [pam_pkg::APB_AW-1:0] PADDR_I,
	input  wire logic [pam_pkg::APB_DW-1:0] PWDATA_I,
	output logic      [pam_pkg::APB_DW-1:0] PRDATA_O,
	output logic                           PREADY_O,
	output logic                           PSLVERR_O,
	input  wire logic                      BYTE_HIGH_DISABLE_STRAP_I,
	input  wire logic                      WRITE_STROBE_CONFIG_STRAP_I,
	input  wire logic                      BUS_ENABLE_STRAP_I,
	input  wire logic [GP_W-1:0]           GP_ALT_OUT_I,
	output logic      [GP_W-1:0]           GP_ALT_IN_O,
	input  wire logic [GP_W-1:0]           GP_PIN_I,
	output logic      [GP_W-1:0]           GP_PIN_O,
	output logic      [GP_W-1:0]           GP_PIN_OE_O,
	input  wire logic                      BUS_DRIVE_I,
	input  wire logic [BUS_W-1:0]          BUS_OUT_I,
	output logic      [BUS_W-1:0]          BUS_IN_O,
	input  wire logic [BUS_W-1:0]          BUS_PIN_I,
	output logic      [BUS_W-1:0]          BUS_PIN_O,
	output logic      [BUS_W-1:0]          BUS_PIN_OE_O,
	input  wire logic [SEG_W-1:0]          SEG_ADDR_I,
	input  wire logic [SEG_W-1:0]          SEG_PIN_I,
	output logic      [SEG_W-1:0]          SEG_PIN_O,
	output logic      [SEG_W-1:0]          SEG_PIN_OE_O,
	input  wire logic                      HOLD_I,
	input  wire logic                      BYTE_HIGH_ENABLE_STROBE_I,
	input  wire logic                      WRITE_HIGH_STROBE_I,
	input  wire logic                      WRITE_STROBE_I,
	input  wire logic                      WRITE_LOW_STROBE_I,
	input  wire logic                      STROBE_PIN_I,
	output logic                           STROBE_PIN_O,
	output logic                           STROBE_PIN_OE_O,
	output logic                           WRITE_PIN_O
);
	import pam_pkg::*;

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [GP_W-1:0]   gp_latch;
		logic [GP_W-1:0]   gp_dir;
		logic [GP_W-1:0]   gp_alt;
		logic [GP_W-1:0]   gp_bypass;
		logic [GP_W-1:0]   gp_out;
		logic [GP_W-1:0]   gp_oe;
		logic [GP_W-1:0]   gp_alt_in;
		logic [BUS_W-1:0]  bus_latch;
		logic [BUS_W-1:0]  bus_dir;
		logic [BUS_W-1:0]  bus_out;
		logic [BUS_W-1:0]  bus_oe;
		logic [BUS_W-1:0]  bus_in;
		logic [SEG_W-1:0]  seg_latch;
		logic [SEG_W-1:0]  seg_dir;
		logic [SEG_W-1:0]  seg_out;
		logic [SEG_W-1:0]  seg_oe;
		logic              str_latch;
		logic              str_dir;
		logic              bhd;
		logic              wcfg;
		logic              bus_en;
		logic              seg_en;
		logic              str_out;
		logic              str_oe;
		logic              wr_out;
		logic              strap_done;
		logic              pready;
		logic              pslverr;
		logic [APB_DW-1:0] prdata;
	} pam_state_s;

	pam_state_s       s_q;
	pam_state_s       s_d;
	logic [GP_W-1:0]  gp_out_c;
	logic [GP_W-1:0]  gp_oe_c;
	logic [GP_W-1:0]  gp_rd_c;
	logic [BUS_W-1:0] bus_out_c;
	logic [BUS_W-1:0] bus_oe_c;
	logic [BUS_W-1:0] bus_rd_c;
	logic [SEG_W-1:0] seg_out_c;
	logic [SEG_W-1:0] seg_oe_c;
	logic [SEG_W-1:0] seg_rd_c;
	logic             str_out_c;
	logic             str_oe_c;
	logic             str_wr_c;
	logic             str_rd_c;

	// ************************************************************
	// Line cells
	// ************************************************************
	// one alternate function per line
	for (genvar i = 0; i < GP_W; i++)
	begin : g_gp
		pam_line_cell u_cell
		(
			.latch_i      (s_q.gp_latch[i]),
			.dir_i        (s_q.gp_dir[i]),
			.alt_en_i     (s_q.gp_alt[i]),
			.alt_bypass_i (s_q.gp_bypass[i]),
			.alt_out_i    (GP_ALT_OUT_I[i]),
			.auto_en_i    (1'h0),
			.auto_oe_i    (1'h0),
			.auto_val_i   (1'h0),
			.pin_i        (GP_PIN_I[i]),
			.out_o        (gp_out_c[i]),
			.oe_o         (gp_oe_c[i]),
			.rd_o         (gp_rd_c[i])
		);
	end

	for (genvar i = 0; i < BUS_W; i++)
	begin : g_bus
		pam_line_cell u_cell
		(
			.latch_i      (s_q.bus_latch[i]),
			.dir_i        (s_q.bus_dir[i]),
			.alt_en_i     (1'h0),
			.alt_bypass_i (1'h0),
			.alt_out_i    (1'h0),
			.auto_en_i    (s_q.bus_en),
			.auto_oe_i    (BUS_DRIVE_I),
			.auto_val_i   (BUS_OUT_I[i]),
			.pin_i        (BUS_PIN_I[i]),
			.out_o        (bus_out_c[i]),
			.oe_o         (bus_oe_c[i]),
			.rd_o         (bus_rd_c[i])
		);
	end

	for (genvar i = 0; i < SEG_W; i++)
	begin : g_seg
		pam_line_cell u_cell
		(
			.latch_i      (s_q.seg_latch[i]),
			.dir_i        (s_q.seg_dir[i]),
			.alt_en_i     (1'h0),
			.alt_bypass_i (1'h0),
			.alt_out_i    (1'h0),
			.auto_en_i    (s_q.seg_en),
			.auto_oe_i    (1'h1),
			.auto_val_i   (SEG_ADDR_I[i]),
			.pin_i        (SEG_PIN_I[i]),
			.out_o        (seg_out_c[i]),
			.oe_o         (seg_oe_c[i]),
			.rd_o         (seg_rd_c[i])
		);
	end

	pam_strobe_cell u_strobe
	(
		.latch_i                   (s_q.str_latch),
		.dir_i                     (s_q.str_dir),
		.byte_high_disable_i       (s_q.bhd),
		.write_strobe_config_i     (s_q.wcfg),
		.hold_i                    (HOLD_I),
		.byte_high_enable_strobe_i (BYTE_HIGH_ENABLE_STROBE_I),
		.write_high_strobe_i       (WRITE_HIGH_STROBE_I),
		.write_strobe_i            (WRITE_STROBE_I),
		.write_low_strobe_i        (WRITE_LOW_STROBE_I),
		.pin_i                     (STROBE_PIN_I),
		.out_o                     (str_out_c),
		.oe_o                      (str_oe_c),
		.wr_o                      (str_wr_c),
		.rd_o                      (str_rd_c)
	);

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb
	begin
		s_d = s_q;
		// Pins are registered so every output leaves a flip-flop; costs one cycle
		s_d.gp_out    = gp_out_c;
		s_d.gp_oe     = gp_oe_c;
		s_d.gp_alt_in = gp_rd_c;
		s_d.bus_out   = bus_out_c;
		s_d.bus_oe    = bus_oe_c;
		s_d.bus_in    = BUS_PIN_I;
		s_d.seg_out   = seg_out_c;
		s_d.seg_oe    = seg_oe_c;
		s_d.str_out   = str_out_c;
		s_d.str_oe    = str_oe_c;
		s_d.wr_out    = str_wr_c;

		// strobe role from straps after release
		if (!s_q.strap_done)
		begin
			s_d.strap_done = 1'h1;
			s_d.bhd        = BYTE_HIGH_DISABLE_STRAP_I;
			s_d.wcfg       = WRITE_STROBE_CONFIG_STRAP_I;
			s_d.bus_en     = BUS_ENABLE_STRAP_I;
		end

		// Zero-wait slave: answer prepared in setup, shown in access
		s_d.pready  = 1'h0;
		s_d.pslverr = 1'h0;
		if (PSEL_I && !PENABLE_I)
		begin
			s_d.pready = 1'h1;
			s_d.prdata = '0;
			case (PADDR_I)
				// read pin or latch by direction
				OFS_GP_DATA:   s_d.prdata[GP_W-1:0]  = gp_rd_c;
				OFS_GP_DIR:    s_d.prdata[GP_W-1:0]  = s_q.gp_dir;
				OFS_GP_ALT:    s_d.prdata[GP_W-1:0]  = s_q.gp_alt;
				OFS_GP_BYPASS: s_d.prdata[GP_W-1:0]  = s_q.gp_bypass;
				OFS_BUS_DATA:  s_d.prdata[BUS_W-1:0] = bus_rd_c;
				OFS_BUS_DIR:   s_d.prdata[BUS_W-1:0] = s_q.bus_dir;
				OFS_SEG_DATA:  s_d.prdata[SEG_W-1:0] = seg_rd_c;
				OFS_SEG_DIR:   s_d.prdata[SEG_W-1:0] = s_q.seg_dir;
				OFS_STROBE:
				begin
					s_d.prdata[STB_LATCH_BIT] = s_q.str_latch;
					s_d.prdata[STB_DIR_BIT]   = s_q.str_dir;
					s_d.prdata[STB_BHD_BIT]   = s_q.bhd;
					s_d.prdata[STB_WCFG_BIT]  = s_q.wcfg;
					s_d.prdata[STB_BUSEN_BIT] = s_q.bus_en;
					s_d.prdata[STB_SEGEN_BIT] = s_q.seg_en;
					s_d.prdata[STB_PIN_BIT]   = str_rd_c;
				end
				default: s_d.pslverr = 1'h1;
			endcase
		end

		// latch writable whatever the direction of the pin
		if (PSEL_I && PENABLE_I && s_q.pready && PWRITE_I && s_q.strap_done)
		begin
			case (PADDR_I)
				OFS_GP_DATA:   s_d.gp_latch  = PWDATA_I[GP_W-1:0];
				OFS_GP_DIR:    s_d.gp_dir    = PWDATA_I[GP_W-1:0];
				OFS_GP_ALT:    s_d.gp_alt    = PWDATA_I[GP_W-1:0];
				OFS_GP_BYPASS: s_d.gp_bypass = PWDATA_I[GP_W-1:0];
				OFS_BUS_DATA:  s_d.bus_latch = PWDATA_I[BUS_W-1:0];
				OFS_BUS_DIR:   s_d.bus_dir   = PWDATA_I[BUS_W-1:0];
				OFS_SEG_DATA:  s_d.seg_latch = PWDATA_I[SEG_W-1:0];
				OFS_SEG_DIR:   s_d.seg_dir   = PWDATA_I[SEG_W-1:0];
				OFS_STROBE:
				begin
					s_d.str_latch = PWDATA_I[STB_LATCH_BIT];
					s_d.str_dir   = PWDATA_I[STB_DIR_BIT];
					s_d.bhd       = PWDATA_I[STB_BHD_BIT];
					s_d.wcfg      = PWDATA_I[STB_WCFG_BIT];
					s_d.bus_en    = PWDATA_I[STB_BUSEN_BIT];
					s_d.seg_en    = PWDATA_I[STB_SEGEN_BIT];
				end
				default:
				begin
					s_d.pslverr = 1'h0;
				end
			endcase
		end
		if (PSEL_I && PENABLE_I && s_q.pready)
			s_d.pslverr = 1'h0;
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge CORE_CLK_I)
	begin
		if (!RSTN_I)
		begin
			s_q            <= '0;
			s_q.gp_latch   <= {GP_W{RST_LATCH}};
			s_q.gp_dir     <= {GP_W{RST_DIR}};
			s_q.gp_alt     <= {GP_W{RST_ALT}};
			s_q.bus_latch  <= {BUS_W{RST_LATCH}};
			s_q.bus_dir    <= {BUS_W{RST_DIR}};
			s_q.seg_latch  <= {SEG_W{RST_LATCH}};
			s_q.seg_dir    <= {SEG_W{RST_DIR}};
			s_q.str_latch  <= RST_LATCH;
			s_q.str_dir    <= RST_DIR;
			s_q.bhd        <= RST_BHD;
			s_q.wcfg       <= RST_WCFG;
			s_q.bus_en     <= RST_BUSEN;
			s_q.seg_en     <= RST_SEGEN;
			s_q.str_out    <= RST_STROBE;
			s_q.wr_out     <= RST_STROBE;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign PRDATA_O        = s_q.prdata;
	assign PREADY_O        = s_q.pready;
	assign PSLVERR_O       = s_q.pslverr;
	assign GP_ALT_IN_O     = s_q.gp_alt_in;
	assign GP_PIN_O        = s_q.gp_out;
	assign GP_PIN_OE_O     = s_q.gp_oe;
	assign BUS_IN_O        = s_q.bus_in;
	assign BUS_PIN_O       = s_q.bus_out;
	assign BUS_PIN_OE_O    = s_q.bus_oe;
	assign SEG_PIN_O       = s_q.seg_out;
	assign SEG_PIN_OE_O    = s_q.seg_oe;
	assign STROBE_PIN_O    = s_q.str_out;
	assign STROBE_PIN_OE_O = s_q.str_oe;
	assign WRITE_PIN_O     = s_q.wr_out;

endmodule : pam_top

/* inc/pam_pkg.sv */
package pam_pkg;

	// ************************************************************
	// Bus widths
	// ************************************************************
	localparam int unsigned APB_AW = 8;
	localparam int unsigned APB_DW = 32;

	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [APB_AW-1:0] OFS_GP_DATA   = 8'h00;
	localparam logic [APB_AW-1:0] OFS_GP_DIR    = 8'h04;
	localparam logic [APB_AW-1:0] OFS_GP_ALT    = 8'h08;
	localparam logic [APB_AW-1:0] OFS_GP_BYPASS = 8'h0C;
	localparam logic [APB_AW-1:0] OFS_BUS_DATA  = 8'h10;
	localparam logic [APB_AW-1:0] OFS_BUS_DIR   = 8'h14;
	localparam logic [APB_AW-1:0] OFS_SEG_DATA  = 8'h18;
	localparam logic [APB_AW-1:0] OFS_SEG_DIR   = 8'h1C;
	localparam logic [APB_AW-1:0] OFS_STROBE    = 8'h20;

	// ************************************************************
	// Strobe control register fields
	// ************************************************************
	localparam int unsigned STB_LATCH_BIT = 0;
	localparam int unsigned STB_DIR_BIT   = 1;
	localparam int unsigned STB_BHD_BIT   = 2;
	localparam int unsigned STB_WCFG_BIT  = 3;
	localparam int unsigned STB_BUSEN_BIT = 4;
	localparam int unsigned STB_SEGEN_BIT = 5;
	localparam int unsigned STB_PIN_BIT   = 6;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic RST_DIR    = 1'h0;
	localparam logic RST_LATCH  = 1'h1;
	localparam logic RST_ALT    = 1'h0;
	localparam logic RST_BHD    = 1'h0;
	localparam logic RST_WCFG   = 1'h0;
	localparam logic RST_BUSEN  = 1'h0;
	localparam logic RST_SEGEN  = 1'h0;
	localparam logic RST_STROBE = 1'h1;

endpackage : pam_pkg

/* rtl/pam_line_cell.sv */
`timescale 1ns/1ps
module pam_line_cell
(
	input  wire logic latch_i,
	input  wire logic dir_i,
	input  wire logic alt_en_i,
	input  wire logic alt_bypass_i,
	input  wire logic alt_out_i,
	input  wire logic auto_en_i,
	input  wire logic auto_oe_i,
	input  wire logic auto_val_i,
	input  wire logic pin_i,
	output logic      out_o,
	output logic      oe_o,
	output logic      rd_o
);

	always_comb
	begin
		if (auto_en_i)
		begin
			oe_o  = auto_oe_i;
			out_o = auto_val_i;
		end
		else
		begin
			oe_o = dir_i;
			if (alt_en_i && alt_bypass_i)
				out_o = alt_out_i;
			else if (alt_en_i)
				out_o = latch_i & alt_out_i;
			else
				out_o = latch_i;
		end
		// output pin reflects latch to alternate input
		rd_o = dir_i ? latch_i : pin_i;
	end

endmodule : pam_line_cell

/* rtl/pam_strobe_cell.sv */
`timescale 1ns/1ps
module pam_strobe_cell
(
	input  wire logic latch_i,
	input  wire logic dir_i,
	input  wire logic byte_high_disable_i,
	input  wire logic write_strobe_config_i,
	input  wire logic hold_i,
	input  wire logic byte_high_enable_strobe_i,
	input  wire logic write_high_strobe_i,
	input  wire logic write_strobe_i,
	input  wire logic write_low_strobe_i,
	input  wire logic pin_i,
	output logic      out_o,
	output logic      oe_o,
	output logic      wr_o,
	output logic      rd_o
);

	logic role_en;

	always_comb
	begin
		role_en = ~byte_high_disable_i | write_strobe_config_i;
		if (role_en && !hold_i)
		begin
			oe_o = 1'h1;
			out_o = write_strobe_config_i ? write_high_strobe_i : byte_high_enable_strobe_i;
		end
		else
		begin
			oe_o  = dir_i;
			out_o = latch_i;
		end
		wr_o = write_strobe_config_i ? write_low_strobe_i : write_strobe_i;
		rd_o = dir_i ? latch_i : pin_i;
	end

endmodule : pam_strobe_cell

/* test/pam_pin_model.sv */
`timescale 1ns/1ps
// ************************************************************
// Pins seen from the board
// ************************************************************
// A line that is not driven shows the level the outside device puts on it.
// Without this, an undriven line would read as whatever the simulator picks.
module pam_pin_model
(
	input  wire logic [15:0] gp_out_i,
	input  wire logic [15:0] gp_oe_i,
	input  wire logic [15:0] bus_out_i,
	input  wire logic [15:0] bus_oe_i,
	input  wire logic [7:0]  seg_out_i,
	input  wire logic [7:0]  seg_oe_i,
	input  wire logic        stb_out_i,
	input  wire logic        stb_oe_i,
	input  wire logic [15:0] ext_i,
	output logic      [15:0] gp_pin_o,
	output logic      [15:0] bus_pin_o,
	output logic      [7:0]  seg_pin_o,
	output logic             stb_pin_o
);
	assign gp_pin_o  = (gp_oe_i & gp_out_i) | (~gp_oe_i & ext_i);
	assign bus_pin_o = (bus_oe_i & bus_out_i) | (~bus_oe_i & ext_i);
	assign seg_pin_o = (seg_oe_i & seg_out_i) | (~seg_oe_i & ext_i[7:0]);
	assign stb_pin_o = stb_oe_i ? stb_out_i : ext_i[0];
endmodule : pam_pin_model

/* test/pam_top_props.sv */
`timescale 1ns/1ps
module pam_props
#(
	parameter int unsigned GP_W  = 16,
	parameter int unsigned BUS_W = 16,
	parameter int unsigned SEG_W = 8
)
(
	input wire logic                       CORE_CLK_I,
	input wire logic                       RSTN_I,
	input wire logic                       PSEL_I,
	input wire logic                       PENABLE_I,
	input wire logic [pam_pkg::APB_DW-1:0] PRDATA_O,
	input wire logic                       PREADY_O,
	input wire logic                       PSLVERR_O,
	input wire logic [GP_W-1:0]            GP_PIN_I,
	input wire logic [GP_W-1:0]            GP_ALT_IN_O,
	input wire logic [GP_W-1:0]            GP_PIN_OE_O,
	input wire logic [BUS_W-1:0]           BUS_PIN_I,
	input wire logic [BUS_W-1:0]           BUS_IN_O,
	input wire logic [BUS_W-1:0]           BUS_PIN_OE_O,
	input wire logic [SEG_W-1:0]           SEG_PIN_OE_O,
	input wire logic                       HOLD_I,
	input wire logic                       WRITE_STROBE_I,
	input wire logic                       WRITE_LOW_STROBE_I,
	input wire logic                       WRITE_PIN_O,
	input wire logic                       STROBE_PIN_OE_O
);
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RSTN_I);
	// ************************************************************
	// Bus handshake
	// ************************************************************
	sequence s_setup; PSEL_I && !PENABLE_I; endsequence
	sequence s_access; PREADY_O ##1 !PREADY_O; endsequence
	property p_ready; s_setup |=> s_access; endproperty
	a_ready: assert property (p_ready) else $error("no single ready after setup");
	property p_idle; !$past(PSEL_I) |-> !PREADY_O; endproperty
	a_idle: assert property (p_idle) else $error("ready without setup");
	property p_err; PSLVERR_O |-> PREADY_O && PRDATA_O == '0; endproperty
	a_err: assert property (p_err) else $error("error outside access");
	// ************************************************************
	// Pins
	// ************************************************************
	property p_rst_oe;
		$rose(RSTN_I) |-> GP_PIN_OE_O == '0 && BUS_PIN_OE_O == '0 && SEG_PIN_OE_O == '0;
	endproperty
	a_rst_oe: assert property (p_rst_oe) else $error("driver on after reset");
	// Strobe driver comes on by itself one edge after release
	property p_stb_rst; $rose(RSTN_I) && !HOLD_I |-> !STROBE_PIN_OE_O ##1 STROBE_PIN_OE_O;
	endproperty
	a_stb_rst: assert property (p_stb_rst) else $error("strobe not taken after reset");
	property p_alt_in;
		$past(RSTN_I) |-> ((GP_ALT_IN_O ^ $past(GP_PIN_I)) & ~GP_PIN_OE_O) == '0;
	endproperty
	a_alt_in: assert property (p_alt_in) else $error("input line not from pin");
	property p_bus_in; $past(RSTN_I) |-> BUS_IN_O == $past(BUS_PIN_I); endproperty
	a_bus_in: assert property (p_bus_in) else $error("bus sample wrong");
	property p_wr;
		$past(RSTN_I) |-> WRITE_PIN_O == $past(WRITE_STROBE_I)
			|| WRITE_PIN_O == $past(WRITE_LOW_STROBE_I);
	endproperty
	a_wr: assert property (p_wr) else $error("write line source wrong");
endmodule : pam_props

bind pam_top pam_props #(.GP_W(GP_W), .BUS_W(BUS_W), .SEG_W(SEG_W)) u_props
(
	.CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
	.PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
	.GP_PIN_I(GP_PIN_I), .GP_ALT_IN_O(GP_ALT_IN_O), .GP_PIN_OE_O(GP_PIN_OE_O),
	.BUS_PIN_I(BUS_PIN_I), .BUS_IN_O(BUS_IN_O), .BUS_PIN_OE_O(BUS_PIN_OE_O),
	.SEG_PIN_OE_O(SEG_PIN_OE_O), .HOLD_I(HOLD_I), .WRITE_STROBE_I(WRITE_STROBE_I),
	.WRITE_LOW_STROBE_I(WRITE_LOW_STROBE_I), .WRITE_PIN_O(WRITE_PIN_O),
	.STROBE_PIN_OE_O(STROBE_PIN_OE_O)
);

/* test/port_alternate_function_mux_bench.sv */
`timescale 1ns/1ps
module port_alternate_function_mux_bench;
	import pam_pkg::*;
	logic clk, rstn, psel, penable, pwrite, drv, hold, bh, wh, ws, wl, pready, pslverr, rerr;
	logic stb_o, stb_oe, stb_pi, wr_o, strap_bhd, strap_wcfg, strap_bus;
	logic [7:0]  paddr, seg_a, seg_o, seg_oe, seg_pi;
	logic [31:0] pwdata, prdata, rdat;
	logic [15:0] alt_out, bout, ext, alt_in, gp_o, gp_oe, gp_pi, bus_in, bus_o, bus_oe, bus_pi;
	int miscompares, checks, cycles;
	pam_top dut (.CORE_CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .BYTE_HIGH_DISABLE_STRAP_I(strap_bhd),
		.WRITE_STROBE_CONFIG_STRAP_I(strap_wcfg), .BUS_ENABLE_STRAP_I(strap_bus),
		.GP_ALT_OUT_I(alt_out), .GP_ALT_IN_O(alt_in), .GP_PIN_I(gp_pi), .GP_PIN_O(gp_o),
		.GP_PIN_OE_O(gp_oe), .BUS_DRIVE_I(drv), .BUS_OUT_I(bout), .BUS_IN_O(bus_in),
		.BUS_PIN_I(bus_pi), .BUS_PIN_O(bus_o), .BUS_PIN_OE_O(bus_oe), .SEG_ADDR_I(seg_a),
		.SEG_PIN_I(seg_pi), .SEG_PIN_O(seg_o), .SEG_PIN_OE_O(seg_oe), .HOLD_I(hold),
		.BYTE_HIGH_ENABLE_STROBE_I(bh), .WRITE_HIGH_STROBE_I(wh), .WRITE_STROBE_I(ws),
		.WRITE_LOW_STROBE_I(wl), .STROBE_PIN_I(stb_pi), .STROBE_PIN_O(stb_o),
		.STROBE_PIN_OE_O(stb_oe), .WRITE_PIN_O(wr_o));
	pam_pin_model u_pins (.gp_out_i(gp_o), .gp_oe_i(gp_oe), .bus_out_i(bus_o),
		.bus_oe_i(bus_oe), .seg_out_i(seg_o), .seg_oe_i(seg_oe), .stb_out_i(stb_o),
		.stb_oe_i(stb_oe), .ext_i(ext), .gp_pin_o(gp_pi), .bus_pin_o(bus_pi),
		.seg_pin_o(seg_pi), .stb_pin_o(stb_pi));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Guard against a hung handshake; the whole run needs far fewer cycles
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			miscompares++;
			stop_test();
		end
	end
	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic stop_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	// Request stands until ready is seen at a rising edge; only the timeout ends a wait
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Pin flops trail their cause by one edge; look between edges
	task automatic settle();
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask : settle
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset();
		apb(1'b0, OFS_GP_DIR, 32'h0);
		chk(rdat, 32'h0);
		chk(gp_oe, 16'h0);
		apb(1'b0, OFS_GP_DATA, 32'h0);
		chk(rdat, {16'h0, ext});
		chk({stb_oe, stb_o}, {1'b1, bh});
		apb(1'b0, 8'h24, 32'h0);
		chk({rerr, rdat}, 33'h1_0000_0000);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_gpio();
		apb(1'b1, OFS_GP_DATA, 32'hA5C3);
		// Latch before direction
		apb(1'b1, OFS_GP_DIR, 32'h00FF);
		settle();
		chk({gp_oe, gp_o}, 32'h00FF_A5C3);
		chk(alt_in, 16'h5AC3);
		apb(1'b0, OFS_GP_DATA, 32'h0);
		chk(rdat, 32'h5AC3);
		$display("t_gpio done");
	endtask : t_gpio
	task automatic t_alt();
		@(posedge clk);
		alt_out <= 16'hFF0F;
		apb(1'b1, OFS_GP_ALT, 32'hFFFF);
		apb(1'b1, OFS_GP_BYPASS, 32'hF000);
		settle();
		// Top nibble bypasses the latch, so it differs from the ANDed value
		chk(gp_o, 16'hF503);
		chk(gp_oe, 16'h00FF);
		apb(1'b1, OFS_GP_ALT, 32'h0);
		settle();
		chk(gp_o, 16'hA5C3);
		$display("t_alt done");
	endtask : t_alt
	task automatic t_bus();
		apb(1'b1, OFS_STROBE, 32'h10);
		@(posedge clk);
		drv <= 1'b1;
		bout <= 16'h1234;
		settle();
		chk({bus_oe, bus_o, bus_in}, 48'hFFFF_1234_1234);
		@(posedge clk);
		drv <= 1'b0;
		settle();
		chk({bus_oe, bus_in}, {16'h0, ext});
		$display("t_bus done");
	endtask : t_bus
	task automatic t_seg();
		apb(1'b1, OFS_STROBE, 32'h20);
		settle();
		chk({seg_oe, seg_o}, {8'hFF, seg_a});
		apb(1'b1, OFS_STROBE, 32'h0);
		apb(1'b1, OFS_SEG_DATA, 32'h3C);
		apb(1'b1, OFS_SEG_DIR, 32'h0F);
		settle();
		chk({seg_oe, seg_o}, 16'h0F3C);
		$display("t_seg done");
	endtask : t_seg
	task automatic t_strobe();
		settle();
		chk({stb_oe, stb_o, wr_o}, {1'b1, bh, ws});
		apb(1'b1, OFS_STROBE, 32'h08);
		settle();
		chk({stb_oe, stb_o, wr_o}, {1'b1, wh, wl});
		@(posedge clk);
		wl <= 1'b1;
		settle();
		chk(wr_o, 1'b1);
		apb(1'b1, OFS_STROBE, 32'h04);
		settle();
		chk(stb_oe, 1'b0);
		apb(1'b1, OFS_STROBE, 32'h02);
		@(posedge clk);
		hold <= 1'b1;
		settle();
		chk({stb_oe, stb_o}, 2'b10);
		apb(1'b1, OFS_STROBE, 32'h0);
		settle();
		chk(stb_oe, 1'b0);
		$display("t_strobe done");
	endtask : t_strobe
	// Second reset with other straps: line freed, bus port in automatic mode
	task automatic t_straps();
		@(posedge clk);
		hold <= 1'b0;
		rstn <= 1'b0;
		strap_bhd <= 1'b1;
		strap_wcfg <= 1'b0;
		strap_bus <= 1'b1;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		apb(1'b0, OFS_STROBE, 32'h0);
		chk(rdat, 32'h15);
		chk(stb_oe, 1'b0);
		$display("t_straps done");
	endtask : t_straps
	initial
	begin
		{rstn, psel, penable, pwrite, drv, hold, wh, wl} = 8'h0;
		{bh, ws} = 2'b11;
		{strap_bhd, strap_wcfg, strap_bus} = 3'h0;
		{paddr, pwdata, alt_out, bout} = 72'h0;
		seg_a = 8'hC5;
		ext = 16'h5A3C;
		{miscompares, checks, cycles} = {32'h0, 32'h0, 32'h0};
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset();
		t_gpio();
		t_alt();
		t_bus();
		t_seg();
		t_strobe();
		t_straps();
		stop_test();
	end
endmodule : port_alternate_function_mux_bench
